/* File: dli_consts.svh */
`ifndef DLI_CONSTS_SVH
`define DLI_CONSTS_SVH

// Register offsets on the internal register port.
`define DLI_OFF_OUT_CFG 8'h00
`define DLI_OFF_MODE_TMO 8'h01
`define DLI_OFF_LIVE_STS 8'h02
`define DLI_OFF_LAT_A 8'h03
`define DLI_OFF_LAT_B 8'h04
`define DLI_OFF_MASK_A 8'h05
`define DLI_OFF_MASK_B 8'h06
`define DLI_OFF_FUSE_STS 8'h07
`define DLI_OFF_REV 8'h08
`define DLI_OFF_SERIAL0 8'h09
`define DLI_OFF_SERIAL5 8'h0e

// Field positions in the output configuration register.
`define DLI_CFG_EN_A 0
`define DLI_CFG_EN_B 1
`define DLI_CFG_OD_A 2
`define DLI_CFG_OD_B 3
`define DLI_CFG_HI_A 4
`define DLI_CFG_HI_B 5

// Field positions in the mode and timeout register.
`define DLI_TMO_MODE_A_LSB 0
`define DLI_TMO_MODE_B_LSB 2
`define DLI_TMO_W1C 4
`define DLI_TMO_CODE_LSB 5

// Event source bit positions.
`define DLI_SRC_DATA_READY 0
`define DLI_SRC_RATE_AND 1
`define DLI_SRC_QUEUE_EMPTY 2
`define DLI_SRC_RATE_OR 3
`define DLI_SRC_QUEUE_LEVEL 4
`define DLI_SRC_SYNC_PIN 5
`define DLI_SRC_QUEUE_OVERFLOW 6
`define DLI_SRC_FUSE_LOADING 7

// Reset values.
`define DLI_RST_BYTE 8'h00
`define DLI_RST_TMO_CNT 10'h000

// Timing: one timeout step and the clock period, both in ns.
`define DLI_TMO_UNIT_NS 1000
`define DLI_CLK_PERIOD_NS 10
`define DLI_TMO_UNIT_CYC ((`DLI_TMO_UNIT_NS + `DLI_CLK_PERIOD_NS - 1) / `DLI_CLK_PERIOD_NS)

`endif

/* File: dli_pkg.sv */
package dli_pkg;

	// Operating mode of one interrupt line.
	typedef enum logic [1:0] {
		DLI_MODE_UNLATCHED = 2'b00,
		DLI_MODE_LATCHED = 2'b01,
		DLI_MODE_TIMED = 2'b10,
		DLI_MODE_SPARE = 2'b11
	} dli_mode_type;

	// Outcome of the fuse download.
	typedef enum logic [1:0] {
		DLI_FUSE_NONE = 2'b00,
		DLI_FUSE_OK_CORRECTED = 2'b01,
		DLI_FUSE_OK_RETRIED = 2'b10,
		DLI_FUSE_ERRORS = 2'b11
	} dli_fuse_type;

	typedef logic [7:0] dli_byte_type;
	typedef logic [9:0] dli_tmo_type;

endpackage

/* File: dli_line_if.sv */
`timescale 1ns/1ps

// Signals between the register block and one interrupt line generator.
interface dli_line_if;
	import dli_pkg::*;
	dli_mode_type mode;
	dli_byte_type mask;
	dli_byte_type live;
	dli_byte_type clr;
	dli_tmo_type tmo_cycles;
	dli_byte_type lat;
	logic act;
	modport gen (input mode, input mask, input live, input clr, input tmo_cycles, output lat, output act);
	modport ctl (output mode, output mask, output live, output clr, output tmo_cycles, input lat, input act);
endinterface

/* File: dli_line_gen.sv */
`timescale 1ns/1ps
`include "dli_consts.svh"

module dli_line_gen (
	// Clock and control.
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	// Line configuration and status.
	dli_line_if.gen lif
);
	import dli_pkg::*;

	logic [7:0] live_prev_reg;
	logic [7:0] lat_reg;
	logic [7:0] lat_next;
	logic [9:0] tmo_reg;
	logic [9:0] tmo_next;

	// Decode of mode and new events.
	wire is_latched = (lif.mode == DLI_MODE_LATCHED);
	wire is_timed = (lif.mode == DLI_MODE_TIMED);
	wire [7:0] rise = lif.live & ~live_prev_reg;
	wire masked_rise = |(rise & lif.mask);

	// Latched bits: a new event wins over a clear in the same cycle; zero outside latched mode.
	assign lat_next = is_latched ? ((lat_reg & ~lif.clr) | rise) : `DLI_RST_BYTE;

	// Timed mode reloads on every enabled event and counts down to release.
	assign tmo_next = !is_timed ? `DLI_RST_TMO_CNT :
		masked_rise ? lif.tmo_cycles :
		(tmo_reg != `DLI_RST_TMO_CNT) ? tmo_reg - 10'h001 : `DLI_RST_TMO_CNT;

	// Line request per mode: live or latched bits gated by the mask, or the timer, which only masked events reload.
	assign lif.act = is_latched ? |(lat_reg & lif.mask) :
		is_timed ? (tmo_reg != `DLI_RST_TMO_CNT) :
		|(lif.live & lif.mask);
	assign lif.lat = lat_reg;

	// State update, frozen while the clock enable is low.
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			live_prev_reg <= `DLI_RST_BYTE;
			lat_reg <= `DLI_RST_BYTE;
			tmo_reg <= `DLI_RST_TMO_CNT;
		end else if (ce_in) begin
			live_prev_reg <= lif.live;
			lat_reg <= lat_next;
			tmo_reg <= tmo_next;
		end
	end
endmodule

/* File: dli_pad_ctrl.sv */
`timescale 1ns/1ps

module dli_pad_ctrl (
	// Clock and control.
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	// Configuration and request.
	input wire logic enable_in,
	input wire logic open_drain_in,
	input wire logic active_high_in,
	input wire logic act_in,
	// Pad.
	output logic level_out,
	output logic oe_out
);
	// A disabled line never asserts, whatever the mask holds.
	wire asserted = enable_in & act_in;
	wire level_next = asserted ? active_high_in : ~active_high_in;
	wire oe_next = open_drain_in ? asserted : 1'b1;

	// Pad flops; after reset the line is released (open-drain style, low level).
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			level_out <= 1'b0;
			oe_out <= 1'b0;
		end else if (ce_in) begin
			level_out <= level_next;
			oe_out <= oe_next;
		end
	end
endmodule

/* File: dli_irq_unit.sv */
`timescale 1ns/1ps
`include "dli_consts.svh"

// Contract
// - A disabled line stays inactive regardless of its mask.
// - Per-line enable, push-pull or open-drain drive, and selectable active level.
// - Each line runs un-latched, latched or timed.
// - Status clears on read or per bit by writing one.
// - One live status register is shared by both lines.
// - An un-latched line is driven straight from live status bits.
// - Live status keeps tracking sources even when lines are latched.
// - Line A latched bits clear on read or by writing ones.
// - Line B latched bits clear on read or by writing ones.
// - Line A latched bits stay zero when not in latched mode.
// - Line B latched bits stay zero when not in latched mode.
// - Latched registers carry the eight documented event sources.
// - A source with mask bit zero never asserts the line.
// - Line B mask selects which line B bits assert line B.
// - Masks may hold any number of set bits; host reads status.
// - Fuse status encodes corrected, retried and error outcomes.
// - Six read-only registers hold a unique part identifier.
// - All registers stay accessible during power-down.
module dli_irq_unit #(
	parameter logic [7:0] REVISION = 8'h01, // Arbitrary value.
	parameter logic [47:0] UNIT_ID = 48'h0123_4567_89ab // Arbitrary value.
) (
	// Clock, reset and clock enable.
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	// Power state, which does not affect register access.
	input wire logic power_down_in,
	// Event sources from same-clock logic.
	input wire dli_pkg::dli_byte_type sources_in,
	input wire dli_pkg::dli_fuse_type fuse_status_in,
	// Register port from the serial host interface.
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire dli_pkg::dli_byte_type reg_wdata_in,
	output dli_pkg::dli_byte_type reg_rdata_out,
	output logic reg_rvalid_out,
	// Interrupt pads.
	output logic irq_line_a_out,
	output logic irq_line_a_oe_out,
	output logic irq_line_b_out,
	output logic irq_line_b_oe_out
);
	import dli_pkg::*;

	dli_byte_type cfg_reg;
	dli_byte_type mode_tmo_reg;
	dli_byte_type mask_a_reg;
	dli_byte_type mask_b_reg;
	dli_byte_type live_reg;
	dli_byte_type rdata_next;
	dli_line_if line_a_if ();
	dli_line_if line_b_if ();

	// Address decode. Power-down has no term here, so access is never blocked.
	wire hit_cfg = (reg_addr_in == `DLI_OFF_OUT_CFG);
	wire hit_mode = (reg_addr_in == `DLI_OFF_MODE_TMO);
	wire hit_live = (reg_addr_in == `DLI_OFF_LIVE_STS);
	wire hit_lat_a = (reg_addr_in == `DLI_OFF_LAT_A);
	wire hit_lat_b = (reg_addr_in == `DLI_OFF_LAT_B);
	wire hit_mask_a = (reg_addr_in == `DLI_OFF_MASK_A);
	wire hit_mask_b = (reg_addr_in == `DLI_OFF_MASK_B);
	wire hit_fuse = (reg_addr_in == `DLI_OFF_FUSE_STS);
	wire hit_rev = (reg_addr_in == `DLI_OFF_REV);
	wire hit_serial = (reg_addr_in >= `DLI_OFF_SERIAL0) && (reg_addr_in <= `DLI_OFF_SERIAL5);
	wire [2:0] serial_idx = 3'(reg_addr_in - `DLI_OFF_SERIAL0);
	wire [7:0] serial_byte = UNIT_ID[{serial_idx, 3'b000} +: 8];

	// Clearing policy: a read clears the whole register, or written ones clear bits.
	wire w1c_policy = mode_tmo_reg[`DLI_TMO_W1C];
	wire [7:0] clr_a = (!w1c_policy && reg_rd_in && hit_lat_a) ? 8'hff :
		(w1c_policy && reg_wr_in && hit_lat_a) ? reg_wdata_in : 8'h00;
	wire [7:0] clr_b = (!w1c_policy && reg_rd_in && hit_lat_b) ? 8'hff :
		(w1c_policy && reg_wr_in && hit_lat_b) ? reg_wdata_in : 8'h00;

	// Timeout length in cycles: code plus one, times one timeout step.
	wire [2:0] tmo_code = mode_tmo_reg[`DLI_TMO_CODE_LSB +: 3];
	wire [9:0] tmo_cycles = 10'(({7'h00, tmo_code} + 10'h001) * 10'(`DLI_TMO_UNIT_CYC));

	// Connections to line A; masks may hold any pattern of ones.
	assign line_a_if.mode = dli_mode_type'(mode_tmo_reg[`DLI_TMO_MODE_A_LSB +: 2]);
	assign line_a_if.mask = mask_a_reg;
	assign line_a_if.live = live_reg;
	assign line_a_if.clr = clr_a;
	assign line_a_if.tmo_cycles = tmo_cycles;

	// Connections to line B, sharing the same live status.
	assign line_b_if.mode = dli_mode_type'(mode_tmo_reg[`DLI_TMO_MODE_B_LSB +: 2]);
	assign line_b_if.mask = mask_b_reg;
	assign line_b_if.live = live_reg;
	assign line_b_if.clr = clr_b;
	assign line_b_if.tmo_cycles = tmo_cycles;

	// Read data selection; unmapped addresses read as zero.
	assign rdata_next = hit_cfg ? cfg_reg :
		hit_mode ? mode_tmo_reg :
		hit_live ? live_reg :
		hit_lat_a ? line_a_if.lat :
		hit_lat_b ? line_b_if.lat :
		hit_mask_a ? mask_a_reg :
		hit_mask_b ? mask_b_reg :
		hit_fuse ? {6'h00, fuse_status_in} :
		hit_rev ? REVISION :
		hit_serial ? serial_byte : 8'h00;

	// Live status follows the sources in every mode.
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			live_reg <= `DLI_RST_BYTE;
		end else if (ce_in) begin
			live_reg <= sources_in;
		end
	end

	// Writable registers.
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			cfg_reg <= `DLI_RST_BYTE;
			mode_tmo_reg <= `DLI_RST_BYTE;
			mask_a_reg <= `DLI_RST_BYTE;
			mask_b_reg <= `DLI_RST_BYTE;
		end else if (ce_in && reg_wr_in) begin
			if (hit_cfg) begin
				cfg_reg <= reg_wdata_in;
			end
			if (hit_mode) begin
				mode_tmo_reg <= reg_wdata_in;
			end
			if (hit_mask_a) begin
				mask_a_reg <= reg_wdata_in;
			end
			if (hit_mask_b) begin
				mask_b_reg <= reg_wdata_in;
			end
		end
	end

	// Read data register; it captures the value before any read-clear takes effect.
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			reg_rdata_out <= `DLI_RST_BYTE;
			reg_rvalid_out <= 1'b0;
		end else if (ce_in) begin
			reg_rvalid_out <= reg_rd_in;
			if (reg_rd_in) begin
				reg_rdata_out <= rdata_next;
			end
		end
	end

	// Line A generator.
	dli_line_gen u_gen_a (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.ce_in(ce_in),
		.lif(line_a_if.gen)
	);

	// Line B generator.
	dli_line_gen u_gen_b (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.ce_in(ce_in),
		.lif(line_b_if.gen)
	);

	// Line A pad with enable, drive type and polarity.
	dli_pad_ctrl u_pad_a (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.ce_in(ce_in),
		.enable_in(cfg_reg[`DLI_CFG_EN_A]),
		.open_drain_in(cfg_reg[`DLI_CFG_OD_A]),
		.active_high_in(cfg_reg[`DLI_CFG_HI_A]),
		.act_in(line_a_if.act),
		.level_out(irq_line_a_out),
		.oe_out(irq_line_a_oe_out)
	);

	// Line B pad with enable, drive type and polarity.
	dli_pad_ctrl u_pad_b (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.ce_in(ce_in),
		.enable_in(cfg_reg[`DLI_CFG_EN_B]),
		.open_drain_in(cfg_reg[`DLI_CFG_OD_B]),
		.active_high_in(cfg_reg[`DLI_CFG_HI_B]),
		.act_in(line_b_if.act),
		.level_out(irq_line_b_out),
		.oe_out(irq_line_b_oe_out)
	);
endmodule

/* File: dli_irq_unit_asserts.sv */
`timescale 1ns/1ps
module dli_irq_unit_asserts #(
	parameter logic [7:0] REVISION = 8'h01,
	parameter logic [47:0] UNIT_ID = 48'h0
) (
	// Clock and control.
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	// Sources and register port.
	input wire dli_pkg::dli_byte_type sources_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire dli_pkg::dli_byte_type reg_wdata_in,
	input wire dli_pkg::dli_byte_type reg_rdata_out,
	input wire logic reg_rvalid_out,
	// Pads.
	input wire logic irq_line_a_out,
	input wire logic irq_line_a_oe_out,
	input wire logic irq_line_b_out,
	input wire logic irq_line_b_oe_out
);
	import dli_pkg::*;
	dli_byte_type sh_reg [0:6];
	dli_byte_type p_reg [0:6];
	wire logic act_a;
	wire logic act_b;
	// Shadow of the writable registers, delayed once more so it lines up with the pad flops.
	always_ff @(posedge clk_in) begin
		for (int i = 0; i < 7; i++) begin
			if (!rst_n_in) begin
				sh_reg[i] <= 8'h00;
			end else if (reg_wr_in && ce_in && reg_addr_in == 8'(i)) begin
				sh_reg[i] <= reg_wdata_in;
			end
			p_reg[i] <= rst_n_in ? sh_reg[i] : 8'h00;
		end
	end
	// A line is asserted when its pad is driven at the configured active level.
	assign act_a = irq_line_a_oe_out && irq_line_a_out == p_reg[0][4];
	assign act_b = irq_line_b_oe_out && irq_line_b_out == p_reg[0][5];
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	// A low clock enable freezes every flop, so each check only counts cycles in which the design moved.
	a_read_answer: assert property (ce_in && reg_rd_in |=> reg_rvalid_out) else $error("read unanswered");
	a_rdata_holds: assert property (ce_in && !reg_rd_in |=> !reg_rvalid_out && $stable(reg_rdata_out))
		else $error("rdata moved");
	a_serial_byte: assert property (ce_in && reg_rd_in && reg_addr_in inside {[8'h09:8'h0e]} |=>
		reg_rdata_out == 8'(UNIT_ID >> (8 * ($past(reg_addr_in) - 8'h09)))) else $error("serial byte wrong");
	a_unmapped_zero: assert property (ce_in && reg_rd_in && reg_addr_in > 8'h0e |=> reg_rdata_out == 8'h00)
		else $error("unmapped");
	a_disabled_a: assert property ($past(rst_n_in) && $past(ce_in) && !p_reg[0][0] |-> !act_a)
		else $error("A active");
	a_pushpull_b: assert property ($past(rst_n_in) && $past(ce_in) && !p_reg[0][3] |-> irq_line_b_oe_out)
		else $error("B oe low");
	a_mask_blocks: assert property ($past(rst_n_in) && $past(ce_in) && p_reg[5] == 8'h00 && p_reg[1][1:0] != 2'b10
		|-> !act_a) else $error("masked A");
	a_unlatched_a: assert property ($past(rst_n_in) && $past(rst_n_in, 2) && $past(ce_in) && $past(ce_in, 2)
		&& p_reg[0][0] && p_reg[1][1:0] == 2'b00 |-> act_a == |($past(sources_in, 2) & p_reg[5])) else $error("A not live");
	a_unlatched_b: assert property ($past(rst_n_in) && $past(rst_n_in, 2) && $past(ce_in) && $past(ce_in, 2)
		&& p_reg[0][1] && p_reg[1][3:2] == 2'b00 |-> act_b == |($past(sources_in, 2) & p_reg[6])) else $error("B not live");
	c_read_a: cover property (reg_rd_in && reg_addr_in == 8'h03);
	c_act_a: cover property (act_a);
	c_act_b: cover property (act_b);
endmodule

bind dli_irq_unit dli_irq_unit_asserts #(.REVISION(REVISION), .UNIT_ID(UNIT_ID)) chk_i (.clk_in, .rst_n_in, .ce_in,
	.sources_in, .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out,
	.irq_line_a_out, .irq_line_a_oe_out, .irq_line_b_out, .irq_line_b_oe_out);

/* File: dli_host_model.sv */
`timescale 1ns/1ps
// Host side of one pad: a resistor pulls an undriven wire to the inactive level.
module dli_host_model (
	// Pad and expected polarity.
	input wire logic level_in,
	input wire logic oe_in,
	input wire logic active_high_in,
	// Request as the host sees it.
	output logic seen_out
);
	wire logic wire_lvl;
	assign wire_lvl = oe_in ? level_in : !active_high_in;
	assign seen_out = wire_lvl == active_high_in;
endmodule

/* File: dli_irq_unit_tb.sv */
`timescale 1ns/1ps
module dli_irq_unit_tb;
	import dli_pkg::*;
	localparam logic [47:0] ID = 48'h5a3c_9612_e7d4; // Arbitrary value.
	logic clk_in;
	logic rst_n_in;
	logic ce_in;
	logic power_down_in;
	dli_byte_type sources_in;
	dli_fuse_type fuse_status_in;
	logic [7:0] reg_addr_in;
	logic reg_wr_in;
	logic reg_rd_in;
	dli_byte_type reg_wdata_in;
	dli_byte_type reg_rdata_out;
	logic reg_rvalid_out;
	logic la, lao, lb, lbo, sa, sb;
	dli_byte_type cfg, v, m, x;
	logic [7:0] ra [4] = '{8'h00, 8'h01, 8'h05, 8'h06};
	int mismatches;
	int samples_checked;
	dli_irq_unit #(.REVISION(8'h77), .UNIT_ID(ID)) dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
		.power_down_in(power_down_in), .sources_in(sources_in), .fuse_status_in(fuse_status_in),
		.reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
		.reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out), .irq_line_a_out(la),
		.irq_line_a_oe_out(lao), .irq_line_b_out(lb), .irq_line_b_oe_out(lbo));
	dli_host_model host_a (.level_in(la), .oe_in(lao), .active_high_in(cfg[4]), .seen_out(sa));
	dli_host_model host_b (.level_in(lb), .oe_in(lbo), .active_high_in(cfg[5]), .seen_out(sb));
	// Clock generation.
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	function automatic dli_byte_type nx(input dli_byte_type s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	function automatic dli_byte_type seen_exp(input logic en, input dli_byte_type s, input dli_byte_type mk);
		return {7'h00, en && (|(s & mk))};
	endfunction
	task automatic chk(input dli_byte_type got, input dli_byte_type exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input dli_byte_type dt);
		@(negedge clk_in);
		reg_addr_in = a;
		reg_wdata_in = dt;
		reg_wr_in = 1'b1;
		@(negedge clk_in);
		reg_wr_in = 1'b0;
	endtask
	// Read strobe for one cycle; data and valid are looked at in the answer cycle.
	task automatic rd(input logic [7:0] a, input dli_byte_type exp);
		@(negedge clk_in);
		reg_addr_in = a;
		reg_rd_in = 1'b1;
		@(negedge clk_in);
		reg_rd_in = 1'b0;
		chk({7'h00, reg_rvalid_out}, 8'h01);
		chk(reg_rdata_out, exp);
	endtask
	// Latch a source pattern, then clear by read and by writing ones.
	task automatic lat_test(input logic [7:0] a, input dli_byte_type md, input dli_byte_type vv);
		x = nx(x);
		m = x;
		sources_in = 8'h00;
		cfg = 8'h33;
		wr(8'h00, cfg);
		wr(8'h05, 8'hff);
		wr(8'h06, 8'hff);
		wr(8'h01, md);
		sources_in = vv;
		repeat (4) @(negedge clk_in);
		chk({7'h00, ((a == 8'h03) ? sa : sb)}, 8'h01);
		rd(8'h02, vv);
		rd(a, vv);
		rd(a, 8'h00);
		chk({7'h00, ((a == 8'h03) ? sa : sb)}, 8'h00);
		sources_in = 8'h00;
		wr(8'h01, md | 8'h10);
		sources_in = vv;
		repeat (4) @(negedge clk_in);
		wr(a, m);
		rd(a, vv & ~m);
		rd(a, vv & ~m);
		chk({7'h00, ((a == 8'h03) ? sa : sb)}, {7'h00, |(vv & ~m)});
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Watchdog well beyond the expected run length.
	initial begin
		#100000;
		mismatches++;
		stop_test;
	end
	initial begin
		rst_n_in = 1'b0;
		power_down_in = 1'b1;
		sources_in = 8'h00;
		fuse_status_in = DLI_FUSE_ERRORS;
		ce_in = 1'b1;
		reg_addr_in = 8'h00;
		reg_wr_in = 1'b0;
		reg_rd_in = 1'b0;
		reg_wdata_in = 8'h00;
		cfg = 8'h00;
		x = 8'h46;
		mismatches = 0;
		samples_checked = 0;
		repeat (2) @(negedge clk_in);
		rst_n_in = 1'b1;
		foreach (ra[i]) begin
			rd(ra[i], 8'h00);
			x = nx(x);
			wr(ra[i], x);
			rd(ra[i], x);
		end
		wr(8'h08, 8'hff);
		rd(8'h08, 8'h77);
		for (int i = 0; i < 6; i++) rd(8'(8'h09 + i), ID[8*i +: 8]);
		rd(8'h20, 8'h00);
		$display("registers done");
		lat_test(8'h03, 8'h01, 8'hff);
		rd(8'h04, 8'h00);
		lat_test(8'h04, 8'h04, x | 8'h01);
		rd(8'h03, 8'h00);
		$display("latched done");
		wr(8'h01, 8'h00);
		repeat (40) begin
			x = nx(x);
			cfg = x;
			wr(8'h00, cfg);
			x = nx(x);
			m = x;
			wr(8'h05, m);
			x = nx(x);
			v = x;
			wr(8'h06, v);
			x = nx(x);
			sources_in = x;
			power_down_in = x[0];
			fuse_status_in = dli_fuse_type'(x[2:1]);
			rd(8'h07, {6'h00, x[2:1]});
			chk({7'h00, sa}, seen_exp(cfg[0], x, m));
			chk({7'h00, sb}, seen_exp(cfg[1], x, v));
		end
		// Clock enable low: the sources move, but live status and both pads must hold.
		ce_in = 1'b0;
		sources_in = ~x;
		repeat (3) @(negedge clk_in);
		chk({7'h00, sa}, seen_exp(cfg[0], x, m));
		chk({7'h00, sb}, seen_exp(cfg[1], x, v));
		ce_in = 1'b1;
		$display("live lines done");
		sources_in = 8'h00;
		wr(8'h05, 8'h01);
		cfg = 8'h11;
		wr(8'h00, cfg);
		wr(8'h01, 8'h02);
		sources_in = 8'h01;
		@(negedge clk_in);
		sources_in = 8'h00;
		repeat (50) @(negedge clk_in);
		chk({7'h00, sa}, 8'h01);
		rd(8'h03, 8'h00);
		repeat (60) @(negedge clk_in);
		chk({7'h00, sa}, 8'h00);
		$display("timed done");
		stop_test;
	end
endmodule
